// ### core/crs_pkg.sv
package crs_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_NS = 50000;
	localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int KEEPOUT_NS = 400;
	localparam int KEEPOUT_CYC = (KEEPOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_NS = 100000;
	localparam int MASK_CYC = MASK_NS / CLK_PERIOD_NS;

	// ****************************************
	// voltage codes
	// ****************************************
	localparam int CODE_W = 7;
	localparam logic [6:0] BOOT_CODE = 7'h18;
	// codes above this sit under 300 mV: only the upper window limit applies
	localparam logic [6:0] LOW_CHECK_MAX_CODE = 7'h60;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_CODE = 4'h8;
	localparam logic CTRL_RESET = 1'h0;
	localparam int CTRL_LATCH_DIS_BIT = 0;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_GOOD_BIT = 6;
	localparam int ST_CLKGO_BIT = 7;
	localparam int ST_PHASE_LSB = 8;
	localparam int ST_TRANS_BIT = 10;
	localparam int ST_PROT_BIT = 11;

	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_RESET = 6'h02,
		ST_PHASE = 6'h04,
		ST_SOFT = 6'h08,
		ST_RUN = 6'h10,
		ST_LATCHED = 6'h20
	} crs_state_t;

	typedef struct packed {
		logic supply_above_upper;
		logic supply_below_lower;
		logic ss_at_1v7;
		logic ss_at_2v9;
		logic ss_below_1v65;
		logic pgd_at_2v9;
		logic core_above_low;
		logic core_below_high;
		logic core_below_200mv;
		logic current_limit_trip;
		logic slew_at_target;
	} crs_cmp_t;

	typedef struct packed {
		logic bias_en;
		logic ss_discharge;
		logic ss_charge_8ua;
		logic ss_fast_charge;
		logic ss_sink_2ua;
		logic pgd_discharge;
		logic pgd_charge_2ua;
		logic slew_sink_2v5;
		logic slew_src_2v5;
		logic slew_src_7v5;
		logic ref_from_slew;
		logic sec_limit_clamp;
	} crs_ramp_t;
endpackage

// ### core/crs_sync2.sv
`timescale 1ns/1ps
module crs_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// first stage feeds only the second stage
	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### core/crs_sequencer.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R01: shutdown or lockout keeps the soft-start ramp discharged
// R02: supply up and enable high start bias and a 50-60 us reset
// R03: after reset, detect phase count, then release the soft-start ramp
// R04: soft start charges the ramp with 8 uA
// R05: output follows the ramp only up to the 1.2 V boot code
// R06: ramp at 1.7 V and output in window drive cpu_clock_go_n low
// R07: after clock go, sample voltage_code and slew softly from boot level
// R08: after clock go, charge the ramp fast to its 2.9 V clamp
// R09: good_delay_ramp held at zero before clock go, then 2 uA charge
// R10: output_good rises when delay ramp reaches 2.9 V and output in window
// R11: clock go to output_good is 3-10 ms, set by external capacitor
// R12: enable low or supply lockout discharge both ramps
// R13: reference follows slew_ramp during transitions, the converter otherwise
// R14: slew current chosen by transition type and sleep requests
// R15: output below 200 mV at start-up engages the 1.5 V secondary clamp
// R16: current limit or good failure sinks 2 uA from the soft-start ramp
// R17: ramp below 1.65 V while discharging latches the controller off
// R18: overload cleared before 1.65 V resumes and recharges to the clamp
// R19: latch cleared only by supply cycle or enable low then high
// R20: a new voltage_code is ignored for at least 400 ns
// R21: each code change restarts the output_good mask timer
// R22: any code transient forces multiphase switching
// R23: processor steps voltage_code one LSB at a time
// R24: output_good mask lasts about 100 us
// R25: window is -300/+200 mV; only upper limit for codes under 300 mV
// R26: current limit forces full-phase switching
// R27: shutdown holds phase outputs and low-side enables low
// R28: every comparator passes a two-stage synchroniser before use
module crs_sequencer #(
	parameter int MASK_CYCLES = crs_pkg::MASK_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic enable,
	input wire logic [6:0] voltage_code,
	input wire logic deep_sleep_req,
	input wire logic deep_stop_req,
	input wire logic phase_reduce_req,
	input wire logic [1:0] phase_cfg,
	input wire crs_pkg::crs_cmp_t cmp_in,
	output crs_pkg::crs_ramp_t ramp_ctl,
	output logic cpu_clock_go_n,
	output logic output_good,
	output logic [6:0] dac_code,
	output logic window_low_check,
	output logic pwm_enable,
	output logic low_side_en,
	output logic force_multiphase,
	output logic [1:0] phases_active
);
	// ****************************************
	// comparator synchronisation
	// ****************************************
	crs_pkg::crs_cmp_t cmp;
	// R28 synchronise comparators
	crs_sync2 #(.W($bits(crs_pkg::crs_cmp_t))) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in(cmp_in),
		.sync_out(cmp)
	);

	crs_pkg::crs_state_t state_reg, state_next;
	logic supply_ok_reg;
	logic [11:0] rst_cnt_reg;
	logic [1:0] phase_count_reg;
	logic [6:0] code_last_reg, code_acc_reg;
	logic [4:0] ko_cnt_reg;
	logic [15:0] mask_cnt_reg;
	logic [1:0] sleep_last_reg;
	logic trans_reg, boot_trans_reg, protect_reg, latch_dis_reg;
	logic win, low_chk, mask_active, good_fail, code_chg, sleep_chg, accept, latch_hit, go_run;
	logic [6:0] dac_next;

	assign low_chk = dac_next <= crs_pkg::LOW_CHECK_MAX_CODE;
	// R25 window, lower limit dropped under 300 mV
	assign win = cmp.core_below_high && (cmp.core_above_low || !low_chk);
	assign mask_active = mask_cnt_reg != 16'h0000;
	assign good_fail = output_good && !win && !mask_active;
	assign code_chg = voltage_code != code_last_reg;
	assign sleep_chg = {deep_sleep_req, deep_stop_req} != sleep_last_reg;
	// R20 accept only after keep-out expires with no further change
	assign accept = state_reg == crs_pkg::ST_RUN && ko_cnt_reg == 5'h01 && !code_chg;
	// R17 latch once ramp drops under threshold while discharging
	assign latch_hit = protect_reg && cmp.ss_below_1v65 && !latch_dis_reg;
	// R06 ramp at 1.7 V and output in boot window
	assign go_run = state_reg == crs_pkg::ST_SOFT && cmp.ss_at_1v7 && win;
	assign dac_next = (state_reg == crs_pkg::ST_RUN || go_run) ? code_acc_reg : crs_pkg::BOOT_CODE;

	// ****************************************
	// supply lockout with hysteresis
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			supply_ok_reg <= 1'b0;
		end else if (cmp.supply_above_upper) begin
			supply_ok_reg <= 1'b1;
		end else if (cmp.supply_below_lower) begin
			supply_ok_reg <= 1'b0;
		end
	end

	// ****************************************
	// sequencing state machine
	// ****************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			crs_pkg::ST_OFF: begin
				// R02 supply and enable start the reset interval
				if (supply_ok_reg && enable) begin
					state_next = crs_pkg::ST_RESET;
				end
			end
			crs_pkg::ST_RESET: begin
				if (rst_cnt_reg == 12'(crs_pkg::RESET_CYC - 1)) begin
					state_next = crs_pkg::ST_PHASE;
				end
			end
			crs_pkg::ST_PHASE: begin
				// R03 ramp released only after phase detection
				state_next = crs_pkg::ST_SOFT;
			end
			crs_pkg::ST_SOFT: begin
				if (go_run) begin
					state_next = crs_pkg::ST_RUN;
				end
			end
			crs_pkg::ST_RUN: begin
				if (latch_hit) begin
					state_next = crs_pkg::ST_LATCHED;
				end
			end
			crs_pkg::ST_LATCHED: begin
				// R19 only lockout or enable low leave the latch
				state_next = crs_pkg::ST_LATCHED;
			end
			default: begin
				state_next = crs_pkg::ST_OFF;
			end
		endcase
		// R12 enable low or lockout force a fresh start
		if (!supply_ok_reg || !enable) begin
			state_next = crs_pkg::ST_OFF;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= crs_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end
	// R02 reset interval counter
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_reg != crs_pkg::ST_RESET) begin
			rst_cnt_reg <= 12'h000;
		end else begin
			rst_cnt_reg <= rst_cnt_reg + 12'h001;
		end
	end
	// R03 phase count captured once per start
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phase_count_reg <= 2'h3;
		end else if (state_reg == crs_pkg::ST_PHASE) begin
			phase_count_reg <= (phase_cfg == 2'h0) ? 2'h1 : phase_cfg;
		end
	end

	// ****************************************
	// voltage code keep-out and transitions
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			code_last_reg <= 7'h00;
			sleep_last_reg <= 2'h0;
			ko_cnt_reg <= 5'h00;
		end else begin
			code_last_reg <= voltage_code;
			sleep_last_reg <= {deep_sleep_req, deep_stop_req};
			// R20 every change restarts the keep-out
			if (code_chg) begin
				ko_cnt_reg <= 5'(crs_pkg::KEEPOUT_CYC);
			end else if (ko_cnt_reg != 5'h00) begin
				ko_cnt_reg <= ko_cnt_reg - 5'h01;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_reg == crs_pkg::ST_OFF) begin
			code_acc_reg <= crs_pkg::BOOT_CODE;
			boot_trans_reg <= 1'b0;
			trans_reg <= 1'b0;
		end else if (go_run) begin
			// R07 first code sampled at clock go, boot slew begins
			code_acc_reg <= voltage_code;
			boot_trans_reg <= 1'b1;
			trans_reg <= 1'b1;
		end else if (accept || (state_reg == crs_pkg::ST_RUN && sleep_chg)) begin
			if (accept) begin
				code_acc_reg <= code_last_reg;
			end
			boot_trans_reg <= 1'b0;
			trans_reg <= 1'b1;
		end else if (cmp.slew_at_target && ko_cnt_reg == 5'h00) begin
			// R13 back to the converter once the slew completes
			trans_reg <= 1'b0;
		end
	end
	// R21 R24 mask timer restarted by code or sleep changes
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_reg != crs_pkg::ST_RUN) begin
			mask_cnt_reg <= 16'h0000;
		end else if (code_chg || sleep_chg) begin
			mask_cnt_reg <= 16'(MASK_CYCLES);
		end else if (mask_active) begin
			mask_cnt_reg <= mask_cnt_reg - 16'h0001;
		end
	end
	// R16 R18 overload tracking; a new fault wins over recovery
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_reg != crs_pkg::ST_RUN) begin
			protect_reg <= 1'b0;
		end else if (cmp.current_limit_trip || good_fail) begin
			protect_reg <= 1'b1;
		end else if (win) begin
			protect_reg <= 1'b0;
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ramp_ctl <= '0;
			cpu_clock_go_n <= 1'b1;
			output_good <= 1'b0;
			dac_code <= crs_pkg::BOOT_CODE;
			window_low_check <= 1'b1;
			pwm_enable <= 1'b0;
			low_side_en <= 1'b0;
			force_multiphase <= 1'b0;
			phases_active <= 2'h0;
		end else begin
			ramp_ctl.bias_en <= state_next != crs_pkg::ST_OFF;
			// R01 R12 ramps shorted while off
			ramp_ctl.ss_discharge <= state_next == crs_pkg::ST_OFF;
			ramp_ctl.pgd_discharge <= state_next != crs_pkg::ST_RUN;
			// R04 constant charge during soft start
			ramp_ctl.ss_charge_8ua <= state_next == crs_pkg::ST_SOFT;
			// R08 R18 fast charge to clamp unless discharging
			ramp_ctl.ss_fast_charge <= state_next == crs_pkg::ST_RUN && !protect_reg && !cmp.ss_at_2v9;
			// R16 sink while overloaded
			ramp_ctl.ss_sink_2ua <= state_next == crs_pkg::ST_RUN && protect_reg;
			// R09 R11 delay ramp charged only after clock go
			ramp_ctl.pgd_charge_2ua <= state_next == crs_pkg::ST_RUN && !cmp.pgd_at_2v9;
			// R13 reference source select
			ramp_ctl.ref_from_slew <= state_next == crs_pkg::ST_RUN && trans_reg;
			// R14 slew current selection
			ramp_ctl.slew_sink_2v5 <= boot_trans_reg ? code_acc_reg > crs_pkg::BOOT_CODE
				: deep_sleep_req && !deep_stop_req;
			ramp_ctl.slew_src_2v5 <= boot_trans_reg ? code_acc_reg <= crs_pkg::BOOT_CODE
				: deep_sleep_req && deep_stop_req;
			ramp_ctl.slew_src_7v5 <= !boot_trans_reg && !deep_sleep_req;
			// R15 secondary clamp during start-up
			ramp_ctl.sec_limit_clamp <= (state_next == crs_pkg::ST_SOFT || state_next == crs_pkg::ST_PHASE)
				&& cmp.core_below_200mv;
			// R06 clock go held while running
			cpu_clock_go_n <= state_next != crs_pkg::ST_RUN;
			// R10 good needs delay ramp and window; mask holds it through transients
			output_good <= state_next == crs_pkg::ST_RUN && !protect_reg && cmp.pgd_at_2v9
				&& (win || (mask_active && output_good));
			// R05 boot code until clock go
			dac_code <= dac_next;
			window_low_check <= low_chk;
			// R27 switching off while shut down or latched
			pwm_enable <= state_next == crs_pkg::ST_SOFT || state_next == crs_pkg::ST_RUN;
			low_side_en <= state_next == crs_pkg::ST_SOFT || state_next == crs_pkg::ST_RUN;
			// R22 R26 transients and current limit force full phases
			force_multiphase <= trans_reg || cmp.current_limit_trip;
			phases_active <= (trans_reg || cmp.current_limit_trip) ? phase_count_reg
				: ((deep_sleep_req || phase_reduce_req) ? 2'h1 : phase_count_reg);
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	// ack follows one cycle after the request; writes land on the ack edge
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			unique case (wb_adr_i)
				crs_pkg::OFS_CTRL: wb_dat_o[crs_pkg::CTRL_LATCH_DIS_BIT] <= latch_dis_reg;
				crs_pkg::OFS_STATUS: begin
					wb_dat_o[crs_pkg::ST_STATE_LSB +: 6] <= state_reg;
					wb_dat_o[crs_pkg::ST_GOOD_BIT] <= output_good;
					wb_dat_o[crs_pkg::ST_CLKGO_BIT] <= !cpu_clock_go_n;
					wb_dat_o[crs_pkg::ST_PHASE_LSB +: 2] <= phase_count_reg;
					wb_dat_o[crs_pkg::ST_TRANS_BIT] <= trans_reg;
					wb_dat_o[crs_pkg::ST_PROT_BIT] <= protect_reg;
				end
				crs_pkg::OFS_CODE: wb_dat_o[6:0] <= code_acc_reg;
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
	// software may disable the latch, like a pull-up on the ramp
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			latch_dis_reg <= crs_pkg::CTRL_RESET;
		end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == crs_pkg::OFS_CTRL) begin
			latch_dis_reg <= wb_dat_i[crs_pkg::CTRL_LATCH_DIS_BIT];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence run_entry_s;
		state_reg == crs_pkg::ST_SOFT && cmp.ss_at_1v7 && win && supply_ok_reg && enable;
	endsequence
	sequence clock_go_s;
		state_reg == crs_pkg::ST_RUN ##0 !cpu_clock_go_n;
	endsequence
	off_ramps_a: assert property (state_reg == crs_pkg::ST_OFF && !supply_ok_reg |=> // R01
		ramp_ctl.ss_discharge && ramp_ctl.pgd_discharge) else $error("ramps not held at zero");
	reset_len_a: assert property ($rose(state_reg == crs_pkg::ST_RESET) && enable |-> // R02
		rst_cnt_reg == 12'h000) else $error("reset interval miscounted");
	phase_first_a: assert property ($rose(state_reg == crs_pkg::ST_SOFT) |-> // R03
		$past(state_reg) == crs_pkg::ST_PHASE) else $error("ramp released before phase detect");
	clock_go_a: assert property (run_entry_s |=> clock_go_s) // R06
		else $error("clock go not asserted");
	pgd_hold_a: assert property (cpu_clock_go_n |-> !ramp_ctl.pgd_charge_2ua) // R09
		else $error("delay ramp charged before clock go");
	good_cause_a: assert property ($rose(output_good) |-> $past(cmp.pgd_at_2v9)) // R10
		else $error("output good without delay ramp");
	latch_off_a: assert property (state_reg == crs_pkg::ST_RUN && latch_hit && supply_ok_reg && enable // R17
		|=> state_reg == crs_pkg::ST_LATCHED) else $error("latch-off missed");
	latch_hold_a: assert property (state_reg == crs_pkg::ST_LATCHED && supply_ok_reg && enable // R19
		|=> state_reg == crs_pkg::ST_LATCHED) else $error("latch released early");
	keep_out_a: assert property (code_chg && !go_run |=> // R20
		($stable(code_acc_reg) || $past(state_reg) != crs_pkg::ST_RUN)[*8]) else $error("code taken inside keep-out");
	mask_restart_a: assert property (state_reg == crs_pkg::ST_RUN && state_next == crs_pkg::ST_RUN // R21
		&& code_chg |=> mask_cnt_reg == 16'(MASK_CYCLES)) else $error("mask not restarted");
	multiphase_a: assert property (trans_reg |=> force_multiphase) // R22
		else $error("multiphase not forced");
endmodule

// ### verif/crs_cpu_model.sv
`timescale 1ns/1ps
// ****************************************
// processor side: code stepping and sleep levels
// ****************************************
module crs_cpu_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [6:0] target,
	input wire logic [5:0] step_gap,
	input wire logic [2:0] sleep_in,
	output logic [6:0] voltage_code,
	output logic deep_sleep_req,
	output logic deep_stop_req,
	output logic phase_reduce_req,
	output logic busy
);
	logic [5:0] gap_reg;
	assign busy = (voltage_code != target);
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			voltage_code <= crs_pkg::BOOT_CODE;
			gap_reg <= 6'h00;
		end else if (gap_reg != 6'h00) begin
			gap_reg <= gap_reg - 6'h01;
		end else if (busy) begin
			voltage_code <= (target > voltage_code) ? voltage_code + 7'h01 : voltage_code - 7'h01;
			gap_reg <= step_gap;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			{phase_reduce_req, deep_stop_req, deep_sleep_req} <= 3'h0;
		end else begin
			{phase_reduce_req, deep_stop_req, deep_sleep_req} <= sleep_in;
		end
	end
endmodule

// ### verif/test_crs_sequencer.sv
`timescale 1ns/1ps
module test_crs_sequencer;
	logic ref_clk = 0, reset_n = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, enable = 0;
	logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0, wb_dat_o, d;
	logic wb_ack_o, cpu_clock_go_n, output_good, window_low_check, pwm_enable, low_side_en, force_multiphase, busy;
	logic [1:0] phase_cfg = 2'h2, phases_active;
	crs_pkg::crs_cmp_t cmp = '0;
	crs_pkg::crs_ramp_t ramp_ctl;
	logic [6:0] dac_code, voltage_code, t, old, target = 7'h18;
	logic [2:0] sleep = 3'h0;
	logic ds, dst, pr, ok;
	int seed = 38546, fail_count = 0, samples_checked = 0, cyc_count = 0, n;
	logic [2:0] tbl [3] = '{3'h1, 3'h0, 3'h3};

	crs_sequencer #(.MASK_CYCLES(50)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enable(enable), .voltage_code(voltage_code),
		.deep_sleep_req(ds), .deep_stop_req(dst), .phase_reduce_req(pr), .phase_cfg(phase_cfg), .cmp_in(cmp),
		.ramp_ctl(ramp_ctl), .cpu_clock_go_n(cpu_clock_go_n), .output_good(output_good), .dac_code(dac_code),
		.window_low_check(window_low_check), .pwm_enable(pwm_enable), .low_side_en(low_side_en),
		.force_multiphase(force_multiphase), .phases_active(phases_active));
	crs_cpu_model u_cpu (.ref_clk(ref_clk), .reset_n(reset_n), .target(target), .step_gap(6'h1E),
		.sleep_in(sleep), .voltage_code(voltage_code), .deep_sleep_req(ds), .deep_stop_req(dst),
		.phase_reduce_req(pr), .busy(busy));

	always #10 ref_clk = ~ref_clk;
	// ****************************************
	// shared tasks
	// ****************************************
	task final_report();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc_count++;
		if (cyc_count == 20000) begin
			fail_count++;
			final_report();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return ramp_ctl.ss_charge_8ua;
			1: return !cpu_clock_go_n;
			2: return output_good;
			3: return voltage_code != old;
			4: return dac_code != old;
			5: return !busy;
			6: return ramp_ctl.ss_sink_2ua;
			default: return ramp_ctl.ss_fast_charge;
		endcase
	endfunction
	// bounded wait; n is the number of edges that passed
	task wait_c(input int k, input int lim, output int cnt);
		cnt = 0;
		while (cond(k) !== 1'b1 && cnt < lim) begin
			@(posedge ref_clk);
			cnt++;
		end
		chk(cnt < lim, 1);
	endtask
	task wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		@(posedge ref_clk);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= wd;
		wb_sel <= 4'hF;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		wb_cyc <= 0;
		wb_stb <= 0;
		wb_we <= 0;
		chk(k < 50, 1);
	endtask
	function automatic logic [2:0] slew_exp(input logic [2:0] s);
		return (s[0] && s[1]) ? 3'h2 : (s[0] ? 3'h4 : 3'h1);
	endfunction
	task start_up(input logic [1:0] cfg);
		phase_cfg <= cfg;
		enable <= 1;
		wait_c(0, crs_pkg::RESET_CYC + 20, n);
		chk(n >= crs_pkg::RESET_CYC, 1);
		@(posedge ref_clk);
		chk(phases_active, (cfg == 2'h0) ? 2'h1 : cfg);
		chk({ramp_ctl.sec_limit_clamp, ramp_ctl.pgd_discharge, cpu_clock_go_n}, 3'h7);
		cmp.core_below_200mv <= 0;
		cmp.ss_at_1v7 <= 1;
		cmp.core_above_low <= 1;
		cmp.core_below_high <= 1;
		wait_c(1, 10, n);
		repeat (2) @(posedge ref_clk);
		chk({ramp_ctl.ss_fast_charge, ramp_ctl.pgd_charge_2ua, output_good}, 3'h6);
		chk(dac_code, target);
		cmp.pgd_at_2v9 <= 1;
		wait_c(2, 80, n);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1;
		repeat (2) @(posedge ref_clk);
		chk({ramp_ctl.bias_en, ramp_ctl.ss_discharge, cpu_clock_go_n, dac_code}, {3'h3, crs_pkg::BOOT_CODE});
		wb_xfer(0, crs_pkg::OFS_STATUS, 0, d);
		chk(d[5:0], crs_pkg::ST_OFF);
		wb_xfer(0, 4'hC, 0, d);
		chk(d, 0);
		wb_xfer(1, crs_pkg::OFS_CTRL, 32'h1, d);
		wb_xfer(0, crs_pkg::OFS_CTRL, 0, d);
		chk(d[0], 1);
		wb_xfer(1, crs_pkg::OFS_CTRL, 32'h0, d);
		target <= 7'h1C;
		cmp.supply_above_upper <= 1;
		cmp.core_below_200mv <= 1;
		start_up(2'h2);
		chk({ramp_ctl.slew_sink_2v5, ramp_ctl.ref_from_slew}, 2'h3);
		cmp.slew_at_target <= 1;
		repeat (40) @(posedge ref_clk);
		chk(ramp_ctl.ref_from_slew, 0);
		// mask must be retriggered by every step to hide the window drop
		old = dac_code;
		target <= dac_code + 7'h3;
		wait_c(3, 100, n);
		cmp.core_above_low <= 0;
		ok = 1;
		repeat (80) @(posedge ref_clk) ok &= output_good;
		chk(ok, 1);
		cmp.core_above_low <= 1;
		for (int i = 0; i < 3; i++) begin
			wait_c(5, 300, n);
			repeat (40) @(posedge ref_clk);
			old = dac_code;
			t = ($random(seed) & 1) ? old + 7'(($random(seed) & 3) + 1) : old - 7'(($random(seed) & 3) + 1);
			target <= t;
			cmp.slew_at_target <= 0;
			wait_c(3, 100, n);
			wait_c(4, 60, n);
			chk(n >= crs_pkg::KEEPOUT_CYC - 1, 1);
			chk(force_multiphase, 1);
			wait_c(5, 300, n);
			repeat (40) @(posedge ref_clk);
			chk({window_low_check, dac_code}, {t <= crs_pkg::LOW_CHECK_MAX_CODE, t});
			cmp.slew_at_target <= 1;
		end
		repeat (40) @(posedge ref_clk);
		chk({force_multiphase, ramp_ctl.ref_from_slew}, 2'h0);
		// step past the 300 mV code: the lower window limit must drop out
		old = dac_code;
		target <= 7'h61;
		wait_c(3, 100, n);
		wait_c(5, 2600, n);
		cmp.core_above_low <= 0;
		repeat (80) @(posedge ref_clk);
		chk({window_low_check, output_good}, 2'h1);
		cmp.core_above_low <= 1;
		for (int i = 0; i < 3; i++) begin
			cmp.slew_at_target <= 0;
			sleep <= tbl[i];
			repeat (8) @(posedge ref_clk);
			chk({ramp_ctl.slew_sink_2v5, ramp_ctl.slew_src_2v5, ramp_ctl.slew_src_7v5}, slew_exp(tbl[i]));
			chk(ramp_ctl.ref_from_slew, 1);
			cmp.slew_at_target <= 1;
			repeat (80) @(posedge ref_clk);
		end
		cmp.core_below_high <= 0;
		wait_c(6, 10, n);
		repeat (4) @(posedge ref_clk);
		chk({output_good, pwm_enable}, 2'h1);
		cmp.core_below_high <= 1;
		wait_c(7, 10, n);
		// let the sleep transient end so only the limit can force full phases
		sleep <= 3'h4;
		repeat (80) @(posedge ref_clk);
		cmp.current_limit_trip <= 1;
		repeat (6) @(posedge ref_clk);
		chk({force_multiphase, ramp_ctl.ss_sink_2ua, phases_active}, 4'hE);
		cmp.ss_below_1v65 <= 1;
		repeat (6) @(posedge ref_clk);
		wb_xfer(0, crs_pkg::OFS_STATUS, 0, d);
		chk(d[5:0], crs_pkg::ST_LATCHED);
		chk({pwm_enable, low_side_en}, 2'h0);
		cmp.current_limit_trip <= 0;
		cmp.ss_below_1v65 <= 0;
		repeat (10) @(posedge ref_clk);
		wb_xfer(0, crs_pkg::OFS_STATUS, 0, d);
		chk(d[5:0], crs_pkg::ST_LATCHED);
		enable <= 0;
		cmp.ss_at_1v7 <= 0;
		cmp.pgd_at_2v9 <= 0;
		cmp.core_below_200mv <= 1;
		repeat (5) @(posedge ref_clk);
		chk({ramp_ctl.ss_discharge, ramp_ctl.pgd_discharge, cpu_clock_go_n}, 3'h7);
		start_up(2'h0);
		cmp.supply_above_upper <= 0;
		cmp.supply_below_lower <= 1;
		repeat (6) @(posedge ref_clk);
		chk({ramp_ctl.ss_discharge, ramp_ctl.pgd_discharge, output_good}, 3'h6);
		final_report();
	end
endmodule
